// file: hw/tws_pkg.sv
/*
   Constants shared by the two-wire serial controller: register selects,
   reset values, field positions, status codes and timing counts.
   Assumes a 250 MHz system clock (4 ns period).
*/
// What this block does
// RQ1: line filters drop spikes under 50 ns
// RQ2: master SCL = clock / (16 + 2*div*4^ps)
// RQ3: slave timing ignores divider; needs 16x oversampling
// RQ4: software keeps divider at 10 or more
// RQ5: 8-bit shift register plus hidden ack bit
// RQ6: START, repeated START, STOP generated and detected; sleep-proof
// RQ7: master watches bus for lost arbitration
// RQ8: address compared to own and general call
// RQ9: own address acknowledged only when ack enabled
// RQ10: other wake during sleep match aborts to idle
// RQ11: event flag first, status code next cycle
// RQ12: flag clear means status shows no-info code
// RQ13: SCL held low while event flag set
// RQ14: listed bus events set the event flag
// RQ15: illegal START or STOP sets the flag
// RQ16: bit rate divider 8-bit read/write, resets zero
// RQ17: control register layout, resets all zero
// RQ18: flag cleared only by writing one
// RQ19: clearing flag starts next bus operation
// RQ20: irq when flag, enable and global enable
// RQ21: data write while inaccessible sets collision flag
// RQ22: prescaler codes divide by 1, 4, 16, 64
// RQ23: status code in upper five status bits
// RQ24: start request waits for STOP when busy
// RQ25: stop request sends STOP then self-clears
// RQ26: lines only pulled low or released
// RQ27: unit disabled releases lines and stays idle
package tws_pkg;
   // timing
   localparam int CLK_NS = 4;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCL_BASE_CYC = 16;
   localparam int HALF_BASE_CYC = SCL_BASE_CYC / 2;
   localparam logic LINE_IDLE = 1'b1;
   // register selects
   localparam logic [2:0] SEL_BIT_RATE = 3'h0;
   localparam logic [2:0] SEL_CONTROL = 3'h1;
   localparam logic [2:0] SEL_STATUS = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam logic [2:0] SEL_OWN_ADDR = 3'h4;
   // reset values
   localparam logic [7:0] BIT_RATE_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [7:0] OWN_ADDR_RST = 8'h00;
   localparam logic [1:0] PS_RST = 2'h0;
   // control bit positions
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_WC = 3;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   // status codes
   localparam logic [4:0] C_BUS_ERR = 5'h00;
   localparam logic [4:0] C_START = 5'h01;
   localparam logic [4:0] C_RSTART = 5'h02;
   localparam logic [4:0] C_MT_SLA_ACK = 5'h03;
   localparam logic [4:0] C_MT_SLA_NACK = 5'h04;
   localparam logic [4:0] C_MT_DATA_ACK = 5'h05;
   localparam logic [4:0] C_MT_DATA_NACK = 5'h06;
   localparam logic [4:0] C_ARB_LOST = 5'h07;
   localparam logic [4:0] C_MR_SLA_ACK = 5'h08;
   localparam logic [4:0] C_MR_SLA_NACK = 5'h09;
   localparam logic [4:0] C_MR_DATA_ACK = 5'h0A;
   localparam logic [4:0] C_MR_DATA_NACK = 5'h0B;
   localparam logic [4:0] C_SR_SLA_W = 5'h0C;
   localparam logic [4:0] C_ARB_LOST_SLA = 5'h0D;
   localparam logic [4:0] C_SR_GC = 5'h0E;
   localparam logic [4:0] C_SR_DATA_ACK = 5'h0F;
   localparam logic [4:0] C_SR_DATA_NACK = 5'h10;
   localparam logic [4:0] C_SLV_STOP = 5'h11;
   localparam logic [4:0] C_ST_SLA_R = 5'h12;
   localparam logic [4:0] C_ST_DATA_ACK = 5'h13;
   localparam logic [4:0] C_ST_DATA_NACK = 5'h14;
   localparam logic [4:0] C_NONE = 5'h1F;
endpackage

// file: hw/tws_glitch_filter.sv
/*
   Spike filter for one bus line: the output follows the input only after
   the input has differed from it for STABLE_CYC consecutive clocks.
   Assumes the line input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module tws_glitch_filter #(
   parameter int STABLE_CYC = tws_pkg::SPIKE_CYC
) (
   // clock and reset
   input logic clk_sys,
   input logic sys_rst,
   // line
   input logic line_in,
   output logic line_filt
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic filt;
   } tws_flt_s;
   tws_flt_s q, d;

   if (STABLE_CYC < 1) begin : g_chk
      $error("tws_glitch_filter: STABLE_CYC must be at least 1");
   end

   always_comb begin
      d = q;
      if (line_in == q.filt) begin
         d.cnt = '0;
      end else if (q.cnt == CW'(STABLE_CYC - 1)) begin
         d.filt = line_in; // see RQ1
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '{cnt: '0, filt: tws_pkg::LINE_IDLE};
      end else begin
         q <= d;
      end
   end

   assign line_filt = q.filt;
endmodule // tws_glitch_filter

// file: hw/tws_rate_gen.sv
/*
   Half-period timer of the master SCL generator: tick rises once
   8 + div*4^ps clocks have passed since the last restart.
   Assumes restart is raised whenever the caller changes phase.
*/
`timescale 1ns/1ps
module tws_rate_gen #(
   parameter int DIV_W = 8
) (
   // clock and reset
   input logic clk_sys,
   input logic sys_rst,
   // control
   input logic restart,
   input logic [DIV_W-1:0] divider,
   input logic [1:0] prescale,
   // timing
   output logic tick
);
   localparam int CW = DIV_W + 7;
   typedef struct packed {
      logic [CW-1:0] cnt;
   } tws_rate_s;
   tws_rate_s q, d;
   logic [CW-1:0] half_m1;

   if (DIV_W < 1 || DIV_W > 16) begin : g_chk
      $error("tws_rate_gen: DIV_W out of range");
   end

   // full period is twice this half, giving 16 + 2*div*4^ps
   assign half_m1 = CW'(tws_pkg::HALF_BASE_CYC - 1)
      + (CW'(divider) << {prescale, 1'b0}); // see RQ2 see RQ22
   assign tick = (q.cnt >= half_m1);

   always_comb begin
      d = q;
      if (restart) begin
         d.cnt = '0;
      end else if (!tick) begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '{cnt: '0};
      end else begin
         q <= d;
      end
   end
endmodule // tws_rate_gen

// file: hw/tws_controller.sv
/*
   Two-wire serial bus controller: register file, START/STOP engine,
   byte shifter, arbitration check, address match and event flag.
   Assumes a CPU register port synchronous to clk_sys and an open-drain
   pad that pulls a line low while its enable is high.
*/
`timescale 1ns/1ps
module tws_controller (
   // clock and reset
   input logic clk_sys,
   input logic sys_rst,
   // cpu register port
   input logic [2:0] reg_sel,
   input logic reg_wr,
   input logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // cpu interrupt and power
   input logic cpu_irq_en,
   output logic irq_req,
   input logic sleep_pd,
   input logic wake_other,
   // bus lines
   input logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_SDA_LO, ST_SCL_LO, ST_LOW, ST_HIGH,
      ST_HOLD, ST_STOP_LO, ST_STOP_HI, ST_RS_LO, ST_SLAVE
   } tws_state_e;

   typedef struct packed {
      tws_state_e st;
      logic [7:0] brd;
      logic flag, ack_en, sta, sto, wc, en, ie;
      logic [1:0] ps;
      logic [4:0] stat;
      logic [4:0] pend;
      logic evt, go;
      logic [7:0] data;
      logic [6:0] own;
      logic gce;
      logic [3:0] bitn;
      logic mst, slv, lost, xmit, is_addr, gc, rx_ack, rs_seen, busy;
      logic scl_drv, sda_drv, scl_p, sda_p;
      logic [7:0] rdata;
   } tws_ctl_s;

   tws_ctl_s q, d;
   logic [1:0] raw, filt;
   logic scl_f, sda_f, tick, tmr_clr, stretch;
   logic scl_rise, scl_fall, start_det, stop_det, engine_on, match, ev;
   logic [4:0] code;

   assign raw = {scl_in, sda_in};
   for (genvar i = 0; i < 2; i++) begin : g_filt
      tws_glitch_filter #(
         .STABLE_CYC(tws_pkg::SPIKE_CYC)
      ) u_filt (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .line_in(raw[i]),
         .line_filt(filt[i])
      );
   end
   assign scl_f = filt[1];
   assign sda_f = filt[0];

   tws_rate_gen #(
      .DIV_W(8)
   ) u_rate (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .restart(tmr_clr),
      .divider(q.brd),
      .prescale(q.ps),
      .tick(tick)
   );

   // line conditions, seen whatever the power state
   assign scl_rise = scl_f & ~q.scl_p;
   assign scl_fall = ~scl_f & q.scl_p;
   assign start_det = scl_f & q.scl_p & q.sda_p & ~sda_f; // see RQ6
   assign stop_det = scl_f & q.scl_p & ~q.sda_p & sda_f; // see RQ6
   assign engine_on = (q.st == ST_LOW) || (q.st == ST_HIGH) || (q.st == ST_SLAVE);
   assign match = q.ack_en && ((q.data[7:1] == q.own)
      || (q.gce && q.data[7:1] == 7'h00)); // see RQ8 see RQ9
   assign stretch = ~scl_f && ((q.st == ST_START) || (q.st == ST_HIGH)
      || (q.st == ST_STOP_HI));

   always_comb begin
      d = q;
      d.evt = 1'b0;
      d.go = 1'b0;
      ev = 1'b0;
      code = tws_pkg::C_NONE;
      d.scl_p = scl_f;
      d.sda_p = sda_f;
      if (start_det) begin
         d.busy = 1'b1;
      end
      if (stop_det) begin
         d.busy = 1'b0;
      end

      // software writes
      if (reg_wr) begin
         case (reg_sel)
            tws_pkg::SEL_BIT_RATE: d.brd = reg_wdata; // see RQ16
            tws_pkg::SEL_CONTROL: begin
               d.ack_en = reg_wdata[tws_pkg::CTL_ACK]; // see RQ17
               d.sta = reg_wdata[tws_pkg::CTL_STA];
               d.sto = reg_wdata[tws_pkg::CTL_STO];
               d.en = reg_wdata[tws_pkg::CTL_EN];
               d.ie = reg_wdata[tws_pkg::CTL_IE];
               if (reg_wdata[tws_pkg::CTL_FLAG]) begin
                  d.flag = 1'b0; // see RQ18
                  d.go = 1'b1; // see RQ19
               end
            end
            tws_pkg::SEL_STATUS: d.ps = reg_wdata[1:0]; // see RQ22
            tws_pkg::SEL_DATA: begin
               if (q.flag) begin
                  d.data = reg_wdata;
                  d.wc = 1'b0;
               end else begin
                  d.wc = 1'b1; // see RQ21
               end
            end
            tws_pkg::SEL_OWN_ADDR: begin
               d.own = reg_wdata[7:1];
               d.gce = reg_wdata[0];
            end
            default: ;
         endcase
      end

      // bus sequencing
      case (q.st)
         ST_IDLE: begin
            d.scl_drv = 1'b0;
            d.sda_drv = 1'b0;
            if (start_det) begin
               d.st = ST_SLAVE;
               d.bitn = 4'h0;
               d.is_addr = 1'b1;
               d.xmit = 1'b0;
               d.slv = 1'b0;
               d.lost = 1'b0;
            end else if (q.sta && !q.busy) begin
               d.st = ST_START; // see RQ24
            end
         end
         ST_START: begin
            if (start_det && !q.mst) begin
               d.st = ST_SLAVE;
               d.bitn = 4'h0;
               d.is_addr = 1'b1;
               d.xmit = 1'b0;
            end else if (tick && scl_f) begin
               d.sda_drv = 1'b1;
               d.st = ST_SDA_LO;
            end
         end
         ST_SDA_LO: begin
            if (tick) begin
               d.scl_drv = 1'b1;
               d.st = ST_SCL_LO;
            end
         end
         ST_SCL_LO: begin
            if (!scl_f) begin
               ev = 1'b1; // see RQ14
               code = q.mst ? tws_pkg::C_RSTART : tws_pkg::C_START;
               d.mst = 1'b1;
               d.is_addr = 1'b1;
               d.xmit = 1'b1;
               d.lost = 1'b0;
               d.bitn = 4'h0;
               d.st = ST_HOLD;
            end
         end
         ST_LOW: begin
            if (tick) begin
               d.scl_drv = 1'b0;
               d.st = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (tick && scl_f) begin
               d.scl_drv = 1'b1;
               d.st = ST_LOW;
            end
         end
         ST_HOLD: begin
            d.scl_drv = 1'b1; // see RQ13
            if (q.go && !q.flag) begin
               if (q.sto) begin
                  if (q.mst) begin
                     d.st = ST_STOP_LO; // see RQ25
                  end else begin
                     d.sto = 1'b0;
                     d.slv = 1'b0;
                     d.sda_drv = 1'b0;
                     d.scl_drv = 1'b0;
                     d.st = ST_IDLE;
                  end
               end else if (q.sta) begin
                  d.st = q.mst ? ST_RS_LO : ST_IDLE;
                  d.scl_drv = q.mst;
               end else if (q.rs_seen) begin
                  d.rs_seen = 1'b0;
                  d.scl_drv = 1'b0;
                  d.bitn = 4'h0;
                  d.is_addr = 1'b1;
                  d.xmit = 1'b0;
                  d.st = ST_SLAVE;
               end else if (q.mst || q.slv) begin
                  d.sda_drv = q.xmit & ~q.data[7];
                  d.scl_drv = q.mst;
                  d.st = q.mst ? ST_LOW : ST_SLAVE;
               end else begin
                  d.scl_drv = 1'b0;
                  d.st = ST_IDLE;
               end
            end
         end
         ST_STOP_LO: begin
            d.sda_drv = 1'b1;
            if (tick) begin
               d.scl_drv = 1'b0;
               d.st = ST_STOP_HI;
            end
         end
         ST_STOP_HI: begin
            if (tick && scl_f) begin
               d.sda_drv = 1'b0;
               d.sto = 1'b0; // see RQ25
               d.mst = 1'b0;
               d.st = ST_IDLE;
            end
         end
         ST_RS_LO: begin
            d.sda_drv = 1'b0;
            if (tick) begin
               d.scl_drv = 1'b0;
               d.st = ST_START;
            end
         end
         ST_SLAVE: begin
            // abort a sleeping address match on a foreign wake-up
            if (sleep_pd && wake_other && !q.slv) begin
               d.st = ST_IDLE; // see RQ10
            end
         end
         default: d.st = ST_IDLE;
      endcase

      // byte engine, shared by master and slave, paced by filtered SCL
      if (engine_on && (start_det || stop_det)) begin
         d.sda_drv = 1'b0;
         if (q.st == ST_SLAVE && !q.slv && !q.lost) begin
            d.bitn = 4'h0;
            d.is_addr = 1'b1;
            d.st = stop_det ? ST_IDLE : ST_SLAVE;
         end else if (q.st == ST_SLAVE && q.slv && q.bitn == 4'h0) begin
            ev = 1'b1; // see RQ14
            code = tws_pkg::C_SLV_STOP;
            d.rs_seen = start_det;
            d.slv = 1'b0;
            d.scl_drv = 1'b1;
            d.st = ST_HOLD;
         end else begin
            ev = 1'b1; // see RQ15
            code = tws_pkg::C_BUS_ERR;
            d.mst = 1'b0;
            d.slv = 1'b0;
            d.lost = 1'b0;
            d.scl_drv = 1'b1;
            d.st = ST_HOLD;
         end
      end else if (engine_on && scl_rise) begin // see RQ3
         if (q.bitn < 4'h8) begin
            d.data = {q.data[6:0], sda_f}; // see RQ5
            if (q.mst && q.xmit && !q.sda_drv && !sda_f) begin
               d.mst = 1'b0; // see RQ7
               d.lost = 1'b1;
               d.xmit = 1'b0;
               d.scl_drv = 1'b0;
               d.st = ST_SLAVE;
            end
         end else begin
            d.rx_ack = ~sda_f; // see RQ5
         end
      end else if (engine_on && scl_fall) begin
         if (q.bitn == 4'h8) begin
            ev = 1'b1; // see RQ14
            d.sda_drv = 1'b0;
            d.bitn = 4'h0;
            d.is_addr = 1'b0;
            d.scl_drv = 1'b1;
            d.st = ST_HOLD;
            if (q.mst) begin
               if (q.is_addr) begin
                  d.xmit = ~q.data[0];
                  if (q.data[0]) begin
                     code = q.rx_ack ? tws_pkg::C_MR_SLA_ACK : tws_pkg::C_MR_SLA_NACK;
                  end else begin
                     code = q.rx_ack ? tws_pkg::C_MT_SLA_ACK : tws_pkg::C_MT_SLA_NACK;
                  end
               end else if (q.xmit) begin
                  code = q.rx_ack ? tws_pkg::C_MT_DATA_ACK : tws_pkg::C_MT_DATA_NACK;
               end else begin
                  code = q.sda_drv ? tws_pkg::C_MR_DATA_ACK : tws_pkg::C_MR_DATA_NACK;
               end
            end else if (q.lost) begin
               d.lost = 1'b0;
               code = q.slv ? tws_pkg::C_ARB_LOST_SLA : tws_pkg::C_ARB_LOST; // see RQ7
            end else if (q.is_addr) begin
               if (q.gc) begin
                  code = tws_pkg::C_SR_GC;
               end else begin
                  code = q.data[0] ? tws_pkg::C_ST_SLA_R : tws_pkg::C_SR_SLA_W;
               end
            end else if (q.xmit) begin
               code = q.rx_ack ? tws_pkg::C_ST_DATA_ACK : tws_pkg::C_ST_DATA_NACK;
            end else begin
               code = q.sda_drv ? tws_pkg::C_SR_DATA_ACK : tws_pkg::C_SR_DATA_NACK;
            end
         end else begin
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == 4'h7) begin
               if (q.is_addr && !q.mst) begin
                  d.sda_drv = match; // see RQ9
                  if (match) begin
                     d.slv = 1'b1; // see RQ8
                     d.gc = (q.data[7:1] == 7'h00);
                     d.xmit = q.data[0];
                  end else if (!q.lost) begin
                     d.st = ST_IDLE;
                  end
               end else begin
                  d.sda_drv = ~q.xmit & (q.mst | q.slv) & q.ack_en; // see RQ5
               end
            end else begin
               d.sda_drv = q.xmit & ~q.data[7];
            end
         end
      end

      // a hardware event wins over a software clear in the same cycle
      if (ev) begin
         d.flag = 1'b1; // see RQ11
         d.pend = code;
         d.evt = 1'b1;
         d.go = 1'b0;
      end
      d.stat = !q.flag ? tws_pkg::C_NONE : (q.evt ? q.pend : q.stat); // see RQ11 see RQ12

      if (!q.en) begin
         d.st = ST_IDLE; // see RQ27
         d.mst = 1'b0;
         d.slv = 1'b0;
         d.lost = 1'b0;
         d.rs_seen = 1'b0;
         d.scl_drv = 1'b0;
         d.sda_drv = 1'b0;
      end

      case (reg_sel)
         tws_pkg::SEL_BIT_RATE: d.rdata = q.brd;
         tws_pkg::SEL_CONTROL: d.rdata = {q.flag, q.ack_en, q.sta, q.sto, q.wc, q.en, 1'b0, q.ie};
         tws_pkg::SEL_STATUS: d.rdata = {q.stat, 1'b0, q.ps}; // see RQ23
         tws_pkg::SEL_DATA: d.rdata = q.data;
         tws_pkg::SEL_OWN_ADDR: d.rdata = {q.own, q.gce};
         default: d.rdata = 8'h00;
      endcase
   end

   assign tmr_clr = (d.st != q.st) || stretch;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.brd <= tws_pkg::BIT_RATE_RST;
         q.ps <= tws_pkg::PS_RST;
         q.stat <= tws_pkg::C_NONE;
         q.pend <= tws_pkg::C_NONE;
         q.data <= tws_pkg::DATA_RST;
         q.own <= tws_pkg::OWN_ADDR_RST[7:1];
         q.gce <= tws_pkg::OWN_ADDR_RST[0];
         q.scl_p <= tws_pkg::LINE_IDLE;
         q.sda_p <= tws_pkg::LINE_IDLE;
      end else begin
         q <= d;
      end
   end

   // open-drain: pull low or release, never drive high
   assign scl_out = 1'b0; // see RQ26
   assign sda_out = 1'b0; // see RQ26
   assign scl_oe = q.scl_drv;
   assign sda_oe = q.sda_drv;
   assign reg_rdata = q.rdata;
   assign irq_req = q.flag & q.ie & cpu_irq_en; // see RQ20
endmodule // tws_controller

// file: sim/tws_controller_sva.sv
/* port checker for the two-wire controller
   assumes binding to tws_controller, one clock domain */
`timescale 1ns/1ps
module tws_controller_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // cpu side
   input wire logic [2:0] reg_sel,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic cpu_irq_en,
   input wire logic irq_req,
   input wire logic sleep_pd,
   input wire logic wake_other,
   // bus lines
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rw(logic [2:0] s, logic [7:0] m);
      logic [7:0] d;
      (reg_wr && reg_sel == s, d = reg_wdata & m) ##1 (reg_sel == s && !reg_wr)
         |=> (reg_rdata & m) == d;
   endproperty
   a_lines_low_only: assert property (!scl_out && !sda_out)
      else $error("bus line driven high");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst
      |=> !scl_oe && !sda_oe && !irq_req && reg_rdata == 8'h00)
      else $error("outputs active after reset");
   a_divider_rw: assert property (p_rw(3'h0, 8'hFF))
      else $error("divider readback wrong");
   a_prescale_rw: assert property (p_rw(3'h2, 8'h03))
      else $error("prescaler readback wrong");
   a_status_bit_two: assert property (reg_sel == 3'h2 |=> !reg_rdata[2])
      else $error("status bit 2 not zero");
   a_ctl_bit_one: assert property (reg_sel == 3'h1 |=> !reg_rdata[1])
      else $error("control bit 1 not zero");
   a_irq_gate: assert property (reg_sel == 3'h1 && cpu_irq_en
      |=> (reg_rdata[7] && reg_rdata[0]) == $past(irq_req))
      else $error("irq not equal to flag and enable");
   a_flag_holds_scl: assert property (irq_req [*2] |-> scl_oe)
      else $error("scl released while flag set");
   a_off_release: assert property (reg_wr && reg_sel == 3'h1 && !reg_wdata[2]
      |-> ##[1:2] (!scl_oe && !sda_oe))
      else $error("lines held while disabled");
   c_flag: cover property ($rose(irq_req));
   c_both_low: cover property (scl_oe && sda_oe);
   c_data_wr: cover property (reg_wr && reg_sel == 3'h3);
endmodule // tws_controller_sva
bind tws_controller tws_controller_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .cpu_irq_en(cpu_irq_en), .irq_req(irq_req), .sleep_pd(sleep_pd),
   .wake_other(wake_other), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// file: sim/tws_slave_model.sv
/* behavioural write-only slave on the wired bus
   assumes resolved, pulled-up scl and sda wires */
`timescale 1ns/1ps
module tws_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter int STRETCH_NS = 200
) (
   // bus wires
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   logic [7:0] sh = 8'h00;
   int n = 99;
   logic first = 1'b0;
   logic hit = 1'b0;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   always @(negedge sda) if (scl === 1'b1) begin
      n = 0;
      first = 1'b1;
      hit = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) n = 99;
   always @(posedge scl) if (n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 1;
   end
   // ack on the ninth clock, then stretch the low phase
   always @(negedge scl) begin
      if (n == 8) begin
         if (first) hit = (sh[7:1] == ADDR) && !sh[0];
         first = 1'b0;
         sda_oe = hit;
         n = 9;
         scl_oe = 1'b1;
         #(STRETCH_NS);
         scl_oe = 1'b0;
      end else if (n == 9) begin
         sda_oe = 1'b0;
         n = 0;
      end
   end
endmodule // tws_slave_model

// file: sim/test_two_wire_serial_controller.sv
/* self-checking bench: register file, master start, bytes, stop
   assumes bound checker and the slave model on pulled-up wires */
`timescale 1ns/1ps
module test_two_wire_serial_controller;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] reg_sel = 3'h0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic cpu_irq_en = 1'b0;
   logic sleep_pd = 1'b0;
   logic wake_other = 1'b0;
   logic [7:0] reg_rdata;
   logic irq_req, scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
   wire logic scl = ~(scl_oe | m_scl_oe);
   wire logic sda = ~(sda_oe | m_sda_oe);
   int fail_count = 0;
   int num_checks = 0;
   always #2 clk_sys = ~clk_sys;
   tws_controller dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cpu_irq_en(cpu_irq_en), .irq_req(irq_req), .sleep_pd(sleep_pd),
      .wake_other(wake_other), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   tws_slave_model #(.ADDR(7'h2A), .STRETCH_NS(200)) slv_u (.scl(scl), .sda(sda),
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(negedge clk_sys);
      reg_sel = s;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rc(input logic [2:0] s, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_sel = s;
      @(negedge clk_sys);
      chk(reg_rdata, exp);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 5000 && irq_req !== 1'b1; i++) @(negedge clk_sys);
      chk({7'h00, irq_req}, 8'h01);
   endtask
   task automatic t_reset;
      logic [7:0] exp [6] = '{8'h00, 8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) rc(3'(i), exp[i]);
   endtask
   task automatic t_regs;
      wr(3'h0, 8'h5A);
      rc(3'h0, 8'h5A);
      wr(3'h2, 8'hFF);
      rc(3'h2, 8'hFB);
      wr(3'h2, 8'h00);
      wr(3'h1, 8'h4B);
      rc(3'h1, 8'h41);
      wr(3'h3, 8'h55);
      rc(3'h1, 8'h49);
      rc(3'h3, 8'hFF);
      wr(3'h5, 8'h77);
      rc(3'h5, 8'h00);
      wr(3'h4, 8'h54);
      rc(3'h4, 8'h54);
      wr(3'h0, 8'h0A);
   endtask
   task automatic t_start;
      wr(3'h1, 8'hA5);
      wait_irq;
      rc(3'h2, 8'h08);
      chk({7'h00, scl_oe}, 8'h01);
      cpu_irq_en = 1'b0;
      #1 chk({7'h00, irq_req}, 8'h00);
      cpu_irq_en = 1'b1;
   endtask
   task automatic t_byte(input logic [7:0] d, input logic [7:0] exp);
      realtime t0;
      wr(3'h3, d);
      wr(3'h1, 8'hC5);
      @(posedge scl);
      t0 = $realtime;
      @(posedge scl);
      num_checks++;
      // full period 16 + 2*10 cycles plus filter lag
      if ($realtime - t0 < 144.0 || $realtime - t0 > 280.0) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, int'($realtime - t0), 144);
      end
      wait_irq;
      rc(3'h2, exp);
      rc(3'h3, d);
   endtask
   task automatic t_stop;
      wr(3'h1, 8'h95);
      for (int i = 0; i < 2000 && (scl_oe !== 1'b0 || sda_oe !== 1'b0); i++)
         @(negedge clk_sys);
      rc(3'h1, 8'h05);
      chk({6'h00, scl, sda}, 8'h03);
      rc(3'h2, 8'hF8);
   endtask
   task automatic close_out;
      $display("checks=%0d failures=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      cpu_irq_en = 1'b1;
      t_reset;
      t_regs;
      t_start;
      t_byte(8'h54, 8'h18);
      t_byte(8'hA5, 8'h28);
      t_stop;
      t_start;
      t_byte(8'h56, 8'h20);
      t_stop;
      close_out;
   end
   initial begin
      #100000;
      fail_count++;
      close_out;
   end
endmodule // test_two_wire_serial_controller
